// ---- tb/serial_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_host #(
  parameter int BC = 16
) (
  // three wires only, ground implied
  input wire logic clk,
  output logic rxd,
  input wire logic txd
);
  logic [7:0] got;
  int n_got = 0;
  initial rxd = 1'b1;
  // start, data lsb first, stop; a low stop forces a fault
  task automatic send(input logic [7:0] b, input logic stop);
    for (int i = 0; i < 10; i++) begin
      rxd <= i == 0 ? 1'b0 : i == 9 ? stop : b[i - 1];
      repeat (BC) @(posedge clk);
    end
    rxd <= 1'b1;
    @(posedge clk);
  endtask
  // sample mid bit, so edge skew cannot flip a bit
  always begin
    @(negedge txd);
    repeat (BC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge clk);
      got[i] = txd;
    end
    n_got++;
  end
endmodule
`default_nettype wire

// ---- tb/serial_port_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_port_assertions #(
  parameter int unsigned BIT_CYC = 16
) (
  // clock, reset and watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] bus_mode,
  input wire logic txd,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_eol,
  input wire logic frame_err,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  import serial_port_pkg::*;
  localparam int GAP = 9 * BIT_CYC - 7;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // txd falls after the second edge past a take, so it is first sampled low at the third
  sequence frame_s;
    ##3 (!txd) [*8] ##GAP txd;
  endsequence
  tx_frame_a: assert property (tx_valid && tx_ready |-> frame_s) else $error("frame");
  tx_busy_a: assert property (tx_valid && tx_ready |=> (!tx_ready) [*8]) else $error("busy");
  idle_high_a: assert property (tx_ready |-> txd) else $error("idle");
  mode_off_a: assert property ((bus_mode != MODE_SERIAL) [*3] |-> !tx_ready && !rx_valid) else $error("mode");
  eol_set_a: assert property (rx_valid && rx_data == LINE_END |-> rx_eol) else $error("eol");
  eol_only_a: assert property (rx_eol |-> rx_valid && rx_data == LINE_END) else $error("eol");
  stop_drop_a: assert property (frame_err |-> !rx_valid ##1 !frame_err) else $error("stop");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid) else $error("pulse");
endmodule
`default_nettype wire
bind remote_serial_port serial_port_assertions #(.BIT_CYC(BIT_CYC)) chk_u (
  .clk(clk),
  .rst(rst),
  .bus_mode(bus_mode),
  .txd(txd),
  .rx_valid(rx_valid),
  .rx_data(rx_data),
  .rx_eol(rx_eol),
  .frame_err(frame_err),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready)
);

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import serial_port_pkg::*;
  logic clk = 0, rst = 1, tx_valid = 0, rxd, txd, rx_valid, rx_eol, frame_err, tx_ready;
  logic [1:0] bus_mode = MODE_SERIAL;
  logic [7:0] tx_data = 8'h00, rx_data;
  int mismatches = 0, n_compared = 0, nv = 0, ne = 0, nl = 0;
  always #12.5 clk = ~clk;
  remote_serial_port #(.BIT_CYC(16)) dut_u (
    .clk(clk),
    .rst(rst),
    .bus_mode(bus_mode),
    .rxd(rxd),
    .txd(txd),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_eol(rx_eol),
    .frame_err(frame_err),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready)
  );
  serial_host #(.BC(16)) host_u (
    .clk(clk),
    .rxd(rxd),
    .txd(txd)
  );
  // pulses last one cycle, so count per edge
  always @(posedge clk) begin
    nv += rx_valid;
    ne += frame_err;
    nl += rx_eol;
  end
  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task print_verdict;
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // request held until ready is seen high at an edge
  task t_tx;
    tx_valid <= 1'b1;
    tx_data <= 8'hc5;
    for (int i = 0; i < 40 && tx_ready !== 1'b1; i++) @(negedge clk);
    chk(tx_ready === 1'b1, "tx ready");
    @(posedge clk);
    tx_valid <= 1'b0;
    repeat (176) @(posedge clk);
    chk(host_u.got === 8'hc5 && host_u.n_got == 1, "tx");
  endtask
  // two bytes closing a line, then one with a low stop
  task t_rx;
    host_u.send(8'h5a, 1'b1);
    chk(nv == 1 && nl == 0 && rx_data === 8'h5a, "rx first");
    host_u.send(LINE_END, 1'b1);
    repeat (4) @(posedge clk);
    chk(nv == 2 && nl == 1 && rx_data === LINE_END, "rx");
    host_u.send(8'h33, 1'b0);
    repeat (4) @(posedge clk);
    chk(nv == 2 && ne == 1 && nl == 1 && rx_data === LINE_END, "stop");
  endtask
  // other mode: traffic ignored, sender closed
  task t_off;
    bus_mode <= MODE_PARALLEL;
    host_u.send(8'h41, 1'b1);
    repeat (4) @(posedge clk);
    chk(nv == 2 && ne == 1 && nl == 1 && tx_ready === 1'b0, "off");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_tx;
    t_rx;
    t_off;
    print_verdict;
  end
  // run needs about 850 cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
endmodule
`default_nettype wire

// ---- verilog/remote_serial_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module remote_serial_port #(
  parameter int unsigned BIT_CYC = serial_port_pkg::BIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // remote mode selection
  input wire logic [1:0] bus_mode,
  // serial pins, no modem controls
  input wire logic rxd,
  output logic txd,
  // received bytes to the command parser
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_eol,
  output logic frame_err,
  // response bytes from the command parser
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  import serial_port_pkg::*;
  typedef enum logic [3:0] {R_IDLE = 4'b0001, R_START = 4'b0010, R_DATA = 4'b0100, R_STOP = 4'b1000} rx_state_t;
  typedef struct packed {
    rx_state_t st;
    logic [12:0] cnt;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic rxs1;
    logic rxs2;
    logic valid;
    logic [7:0] data;
    logic eol;
    logic ferr;
    logic txd;
    logic txrdy;
  } rx_t;
  rx_t s_reg, s_next;
  logic active;
  logic tx_line;
  serial_byte_if tx_bus ();
  // the half-bit start check needs four cycles a bit; the cycle counters are 13 bits wide
  if (BIT_CYC < 4 || BIT_CYC > 8191) begin
    $error("BIT_CYC out of range");
  end
  // only the serial selection lets the port act
  assign active = (bus_mode == MODE_SERIAL);
  assign tx_bus.valid = tx_valid & active & s_reg.txrdy;
  assign tx_bus.data = tx_data;
  serial_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk(clk),
    .rst(rst),
    .in(tx_bus),
    .txd(tx_line)
  );
  assign txd = s_reg.txd;
  assign tx_ready = s_reg.txrdy;
  assign rx_valid = s_reg.valid;
  assign rx_data = s_reg.data;
  assign rx_eol = s_reg.eol;
  assign frame_err = s_reg.ferr;
  // receiver: two-flop line then mid-bit sampling
  always_comb begin
    s_next = s_reg;
    s_next.rxs1 = rxd;
    s_next.rxs2 = s_reg.rxs1;
    s_next.valid = 1'b0;
    s_next.eol = 1'b0;
    s_next.ferr = 1'b0;
    s_next.txd = tx_line;
    // ready is registered so the top output comes from a flop; one idle gap per byte
    s_next.txrdy = tx_bus.ready & active & ~(tx_valid & s_reg.txrdy);
    s_next.cnt = s_reg.cnt + 13'h0001;
    case (s_reg.st)
      R_IDLE: begin
        s_next.cnt = 13'h0000;
        if (active && !s_reg.rxs2) begin
          s_next.st = R_START;
        end
      end
      R_START: begin
        if (s_reg.cnt == 13'(BIT_CYC / 2 - 1)) begin
          s_next.cnt = 13'h0000;
          s_next.bitn = 3'h0;
          // a glitch shorter than half a bit is not a start
          s_next.st = s_reg.rxs2 ? R_IDLE : R_DATA;
        end
      end
      R_DATA: begin
        if (s_reg.cnt == 13'(BIT_CYC - 1)) begin
          s_next.cnt = 13'h0000;
          s_next.sh = {s_reg.rxs2, s_reg.sh[7:1]};
          if (s_reg.bitn == 3'(DATA_BITS - 1)) begin
            s_next.st = R_STOP;
          end else begin
            s_next.bitn = s_reg.bitn + 3'h1;
          end
        end
      end
      R_STOP: begin
        if (s_reg.cnt == 13'(BIT_CYC - 1)) begin
          s_next.st = R_IDLE;
          // a frame that ends after deselection is dropped silently, error included
          if (!active) begin
            s_next.valid = 1'b0;
          end else if (!s_reg.rxs2) begin
            s_next.ferr = 1'b1;
          end else begin
            s_next.valid = 1'b1;
            s_next.data = s_reg.sh;
            s_next.eol = (s_reg.sh == LINE_END);
          end
        end
      end
      default: s_next.st = R_IDLE;
    endcase
  end
  // command set coverage lives in the parser fed by rx_valid/rx_eol
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: R_IDLE, cnt: 13'h0000, bitn: 3'h0, sh: 8'h00, rxs1: 1'b1, rxs2: 1'b1,
                 valid: 1'b0, data: 8'h00, eol: 1'b0, ferr: 1'b0, txd: 1'b1, txrdy: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/serial_byte_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface serial_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- verilog/serial_port_pkg.sv ----
package serial_port_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BAUD_BPS = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [7:0] LINE_END = 8'h0a;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_SERIAL = 2'h1;
  localparam logic [1:0] MODE_PARALLEL = 2'h2;
endpackage

// ---- verilog/serial_tx.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_tx #(
  parameter int unsigned BIT_CYC = 4166
) (
  input wire logic clk,
  input wire logic rst,
  serial_byte_if.dst in,
  output logic txd
);
  import serial_port_pkg::*;
  typedef enum logic [1:0] {T_IDLE = 2'b01, T_SHIFT = 2'b10} tx_state_t;
  typedef struct packed {
    tx_state_t st;
    logic [12:0] cnt;
    logic [3:0] bitn;
    logic [9:0] sh;
    logic line;
  } tx_t;
  tx_t s_reg, s_next;
  // the bit-time counter cnt is 13 bits wide
  if (BIT_CYC < 2 || BIT_CYC > 8191) begin
    $error("BIT_CYC out of range");
  end
  assign in.ready = (s_reg.st == T_IDLE);
  assign txd = s_reg.line;
  // shift out start, eight data lsb first, stop
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      T_IDLE: begin
        s_next.line = 1'b1;
        if (in.valid) begin
          s_next.sh = {1'b1, in.data, 1'b0};
          s_next.cnt = 13'h0000;
          s_next.bitn = 4'h0;
          s_next.st = T_SHIFT;
        end
      end
      T_SHIFT: begin
        s_next.line = s_reg.sh[0];
        if (s_reg.cnt == 13'(BIT_CYC - 1)) begin
          s_next.cnt = 13'h0000;
          s_next.sh = {1'b1, s_reg.sh[9:1]};
          if (s_reg.bitn == 4'h9) begin
            s_next.st = T_IDLE;
            s_next.line = 1'b1;
          end else begin
            s_next.bitn = s_reg.bitn + 4'h1;
          end
        end else begin
          s_next.cnt = s_reg.cnt + 13'h0001;
        end
      end
      default: s_next.st = T_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: T_IDLE, cnt: 13'h0000, bitn: 4'h0, sh: 10'h3ff, line: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire
